//--- lp_clk_div.sv
// enable-pulse clock divider; a divide value of zero stops the output
// assumes run drops whenever the root clock it follows is gated
`timescale 1ns/100ps
module lp_clk_div (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [7:0] div,
    output logic            tick
);
    logic [7:0] cnt;
    wire        stopped = !run || (div == 8'h00);
    wire        wrap    = (cnt >= div - 8'h01);

    always_ff @(posedge clk_sys) begin
        if (rst || stopped) begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt  <= wrap ? 8'h00 : cnt + 8'h01;
            tick <= wrap;
        end
    end
endmodule : lp_clk_div

//--- lp_consts.svh
// register offsets, reset values and timing counts of the low power mode controller
// assumes a 20 MHz system clock and a byte-addressed plain register port
//
// How it works
// - any reset returns to active mode with power and gate registers at reset values
// - four reduced modes chosen through the low power entry call register
// - debug is refused whenever the core is in any reduced mode
// - gate registers clock blocks; analog config powers each analog block separately
// - system clock source selectable, internal rc oscillator after reset
// - a peripheral divider set to zero stops its clock, root keeps running
// - sleep stops only the processor clock until interrupt or reset
// - gated-on peripherals keep running in sleep and can wake the core
// - sleep, deep-sleep and power-down keep state and hold pins static
// - interrupt wake keeps configuration; reset restores default active configuration
// - deep-sleep stops rc oscillator and all clocks except a watchdog clock on the watchdog oscillator, flash in standby
// - non-reset wake from deep-sleep or power-down needs start enable and interrupt controller enable
// - eight pin interrupts wake deep-sleep when enabled in start enable zero
// - reset pin always wakes; brownout or watchdog reset only when kept on
// - serial, watchdog, rtc and gpio group events wake deep-sleep
// - power-down gates clocks, powers flash down, watchdog clock may keep running
// - power-down wake takes longer than deep-sleep wake, analog settling
`ifndef LP_CONSTS_SVH
`define LP_CONSTS_SVH

`define LP_ADDR_PD_CFG     8'h00
`define LP_ADDR_GATE0      8'h04
`define LP_ADDR_GATE1      8'h08
`define LP_ADDR_WAKE_EN0   8'h0C
`define LP_ADDR_WAKE_EN1   8'h10
`define LP_ADDR_BUS_DIV    8'h14
`define LP_ADDR_CLK_SEL    8'h18
`define LP_ADDR_ENTRY      8'h1C
`define LP_ADDR_STATUS     8'h20
`define LP_ADDR_PERIPH_DIV 8'h24

// analog_powerdown_config: a set bit powers the block down
`define LP_PD_RAM    0
`define LP_PD_PLL    1
`define LP_PD_SYSOSC 2
`define LP_PD_IRC    3
`define LP_PD_WDOSC  4
`define LP_PD_BOD    5
`define LP_PD_FLASH  6
`define LP_PD_OSC32K 7

`define LP_RST_PD_CFG     8'h96
`define LP_RST_GATE0      32'h0000_00FF
`define LP_RST_GATE1      32'h0000_0000
`define LP_RST_WAKE_EN    32'h0000_0000
`define LP_RST_BUS_DIV    8'h01
`define LP_RST_PERIPH_DIV 8'h01
`define LP_RST_ENTRY      16'h0000

// entry call fields: mode in the low bits, keep-on mask per analog block above
`define LP_ENTRY_MODE_LO 0
`define LP_ENTRY_MODE_HI 1
`define LP_ENTRY_KEEP_LO 8
`define LP_ENTRY_KEEP_HI 15

// pin interrupts occupy the low byte of wake source 0, gpio group is bit 0 of source 1
`define LP_GPIO_GROUP_BIT 0

`define LP_CLK_NS        50
`define LP_DS_WAKE_NS    10000
`define LP_PD_WAKE_NS    50000
`define LP_DS_WAKE_CYC   ((`LP_DS_WAKE_NS + `LP_CLK_NS - 1) / `LP_CLK_NS)
`define LP_PD_WAKE_CYC   ((`LP_PD_WAKE_NS + `LP_CLK_NS - 1) / `LP_CLK_NS)

`endif

//--- lp_core_model.sv
// core model: register port master, wait-for-interrupt and pending interrupt
// assumes clk_sys from the bench; the bench calls the tasks by hierarchy
`timescale 1ns/100ps
`include "lp_consts.svh"
module lp_core_model (
    input  wire logic        clk_sys,
    output lp_pkg::reg_req_t reg_req,
    output logic             wait_for_interrupt_instruction,
    output logic             irq_pending
);
    initial begin
        reg_req = '0;
        wait_for_interrupt_instruction = 1'b0;
        irq_pending = 1'b0;
    end
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        reg_req.wdata <= ~d; // released data never shows the old word
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
    endtask : reg_rd
    task automatic set_irq(input logic v);
        @(posedge clk_sys);
        irq_pending <= v;
    endtask : set_irq
    // wake enables and clock choice are set up by the caller beforehand
    task automatic enter_mode(input logic [1:0] m, input logic [7:0] keep);
        reg_wr(`LP_ADDR_ENTRY, {16'h0000, keep, 6'h00, m});
        @(posedge clk_sys);
        wait_for_interrupt_instruction <= 1'b1;
        @(posedge clk_sys);
        wait_for_interrupt_instruction <= 1'b0;
    endtask : enter_mode
endmodule : lp_core_model

//--- lp_pkg.sv
// types shared by the low power mode controller and its register port
// assumes the constants header for widths of fields
package lp_pkg;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_DEEP_SLEEP,
        MODE_POWER_DOWN,
        MODE_DEEP_PD
    } lp_mode_t;

    typedef enum logic [1:0] {
        SRC_IRC,
        SRC_SYSOSC,
        SRC_OSC32K,
        SRC_WDOSC
    } clk_src_t;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_DEEP_SLEEP,
        ST_POWER_DOWN,
        ST_DEEP_PD,
        ST_SETTLE
    } power_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        cpu_clk_en;
        logic        main_clk_en;
        logic [63:0] periph_clk_en;
        logic        wdt_clk_en;
        logic        irc_en;
        logic        flash_standby;
        logic        flash_powerdown;
        logic [7:0]  analog_en;
    } clk_ctrl_t;

endpackage : lp_pkg

//--- lp_power_ctrl.sv
// low power mode controller: registers, mode sequencer, clock and power gating
// assumes wfi and wake inputs are synchronous single-clock signals from the core side
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "lp_consts.svh"
module lp_power_ctrl (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire lp_pkg::reg_req_t  reg_req,
    output logic [31:0]            reg_rdata,
    input  wire logic              wait_for_interrupt_instruction,
    input  wire logic              irq_pending,
    input  wire logic [31:0]       wake_src0,
    input  wire logic [31:0]       wake_src1,
    input  wire logic [31:0]       nested_interrupt_controller_en0,
    input  wire logic [31:0]       nested_interrupt_controller_en1,
    input  wire logic              bod_reset_in,
    input  wire logic              wdt_reset_in,
    output logic                   reset_req,
    output lp_pkg::clk_ctrl_t      clk_ctrl,
    output logic [1:0]             clk_sel,
    output logic                   bus_tick,
    output logic                   periph_tick,
    output logic                   debug_en,
    output logic                   pin_hold
);
    lp_pkg::power_state_t state;
    lp_pkg::power_state_t next_state;
    lp_pkg::clk_ctrl_t    next_clk;

    logic [7:0]  pd_cfg;
    logic [31:0] gate0;
    logic [31:0] gate1;
    logic [31:0] wake_en0;
    logic [31:0] wake_en1;
    logic [7:0]  bus_div;
    logic [7:0]  periph_div;
    logic [1:0]  clk_src;
    logic [15:0] entry;

    // named copy of the reset word, a literal cannot be bit-selected
    wire [7:0] pd_cfg_rst = `LP_RST_PD_CFG;

    // register port decode
    wire wr_pd     = reg_req.wr && reg_req.addr == `LP_ADDR_PD_CFG;
    wire wr_gate0  = reg_req.wr && reg_req.addr == `LP_ADDR_GATE0;
    wire wr_gate1  = reg_req.wr && reg_req.addr == `LP_ADDR_GATE1;
    wire wr_wake0  = reg_req.wr && reg_req.addr == `LP_ADDR_WAKE_EN0;
    wire wr_wake1  = reg_req.wr && reg_req.addr == `LP_ADDR_WAKE_EN1;
    wire wr_busdiv = reg_req.wr && reg_req.addr == `LP_ADDR_BUS_DIV;
    wire wr_clksel = reg_req.wr && reg_req.addr == `LP_ADDR_CLK_SEL;
    wire wr_entry  = reg_req.wr && reg_req.addr == `LP_ADDR_ENTRY;
    wire wr_pdiv   = reg_req.wr && reg_req.addr == `LP_ADDR_PERIPH_DIV;

    wire [31:0] status_word = {26'h000_0000, debug_en, pin_hold, 1'b0, state};
    wire [31:0] rd_mux =
        (reg_req.addr == `LP_ADDR_PD_CFG)     ? {24'h00_0000, pd_cfg}     :
        (reg_req.addr == `LP_ADDR_GATE0)      ? gate0                     :
        (reg_req.addr == `LP_ADDR_GATE1)      ? gate1                     :
        (reg_req.addr == `LP_ADDR_WAKE_EN0)   ? wake_en0                  :
        (reg_req.addr == `LP_ADDR_WAKE_EN1)   ? wake_en1                  :
        (reg_req.addr == `LP_ADDR_BUS_DIV)    ? {24'h00_0000, bus_div}    :
        (reg_req.addr == `LP_ADDR_CLK_SEL)    ? {30'h0000_0000, clk_src}  :
        (reg_req.addr == `LP_ADDR_ENTRY)      ? {16'h0000, entry}         :
        (reg_req.addr == `LP_ADDR_STATUS)     ? status_word               :
        (reg_req.addr == `LP_ADDR_PERIPH_DIV) ? {24'h00_0000, periph_div} :
        32'h0000_0000;

    // configuration is untouched by mode changes, only by reset or writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pd_cfg     <= `LP_RST_PD_CFG;
            gate0      <= `LP_RST_GATE0;
            gate1      <= `LP_RST_GATE1;
            wake_en0   <= `LP_RST_WAKE_EN;
            wake_en1   <= `LP_RST_WAKE_EN;
            bus_div    <= `LP_RST_BUS_DIV;
            periph_div <= `LP_RST_PERIPH_DIV;
            clk_src    <= lp_pkg::SRC_IRC;
            entry      <= `LP_RST_ENTRY;
        end else begin
            if (wr_pd)     pd_cfg     <= reg_req.wdata[7:0];
            if (wr_gate0)  gate0      <= reg_req.wdata;
            if (wr_gate1)  gate1      <= reg_req.wdata;
            if (wr_wake0)  wake_en0   <= reg_req.wdata;
            if (wr_wake1)  wake_en1   <= reg_req.wdata;
            if (wr_busdiv) bus_div    <= reg_req.wdata[7:0];
            if (wr_clksel) clk_src    <= reg_req.wdata[1:0];
            if (wr_entry)  entry      <= reg_req.wdata[15:0];
            if (wr_pdiv)   periph_div <= reg_req.wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_req.rd)
            reg_rdata <= rd_mux;
    end

    // wake qualification
    wire [1:0] sel_mode = entry[`LP_ENTRY_MODE_HI:`LP_ENTRY_MODE_LO];
    wire [7:0] keep_on  = entry[`LP_ENTRY_KEEP_HI:`LP_ENTRY_KEEP_LO];
    wire [31:0] wake_hit0 = wake_src0 & wake_en0 & nested_interrupt_controller_en0;
    wire [31:0] wake_hit1 = wake_src1 & wake_en1 & nested_interrupt_controller_en1;
    // pin interrupts sit in the low byte; gpio group, serial, watchdog, rtc elsewhere
    wire pin_wake   = |wake_hit0[7:0];
    wire other_wake = |wake_hit0[31:8] | |wake_hit1;
    wire deep_wake  = pin_wake | other_wake;
    wire low_state  = state == lp_pkg::ST_DEEP_SLEEP || state == lp_pkg::ST_POWER_DOWN;
    wire keep_bod   = keep_on[`LP_PD_BOD];
    wire keep_wdosc = keep_on[`LP_PD_WDOSC];
    wire next_reset_req = low_state
                        ? ((bod_reset_in && keep_bod) || (wdt_reset_in && keep_wdosc))
                        : (bod_reset_in || wdt_reset_in);

    wire settle_done;
    wire settle_load = low_state && deep_wake;
    wire [10:0] settle_count = (state == lp_pkg::ST_POWER_DOWN)
                             ? 11'(`LP_PD_WAKE_CYC)
                             : 11'(`LP_DS_WAKE_CYC);

    lp_settle_timer u_settle (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (settle_load),
        .count   (settle_count),
        .done    (settle_done)
    );

    // a pending wake skips entry, except into deep power-down, so the wfi simply falls through
    wire entry_blocked = (sel_mode == lp_pkg::MODE_SLEEP) ? irq_pending
                       : (sel_mode == lp_pkg::MODE_DEEP_PD) ? 1'b0
                       : (deep_wake || irq_pending);

    always_comb begin
        next_state = state;
        unique case (state)
            lp_pkg::ST_ACTIVE: begin
                if (wait_for_interrupt_instruction && !entry_blocked) begin
                    unique case (sel_mode)
                        lp_pkg::MODE_SLEEP:      next_state = lp_pkg::ST_SLEEP;
                        lp_pkg::MODE_DEEP_SLEEP: next_state = lp_pkg::ST_DEEP_SLEEP;
                        lp_pkg::MODE_POWER_DOWN: next_state = lp_pkg::ST_POWER_DOWN;
                        lp_pkg::MODE_DEEP_PD:    next_state = lp_pkg::ST_DEEP_PD;
                    endcase
                end
            end
            lp_pkg::ST_SLEEP: begin
                if (irq_pending)
                    next_state = lp_pkg::ST_ACTIVE;
            end
            lp_pkg::ST_DEEP_SLEEP, lp_pkg::ST_POWER_DOWN: begin
                if (deep_wake)
                    next_state = lp_pkg::ST_SETTLE;
            end
            // only the reset pin leaves deep power-down
            lp_pkg::ST_DEEP_PD: next_state = lp_pkg::ST_DEEP_PD;
            lp_pkg::ST_SETTLE: begin
                if (settle_done)
                    next_state = lp_pkg::ST_ACTIVE;
            end
            default: next_state = lp_pkg::ST_ACTIVE;
        endcase
    end

    // gating follows the next state so outputs change with the state register
    wire nx_run   = next_state == lp_pkg::ST_ACTIVE || next_state == lp_pkg::ST_SLEEP;
    wire nx_deep  = next_state == lp_pkg::ST_DEEP_SLEEP;
    wire nx_pd    = next_state == lp_pkg::ST_POWER_DOWN;
    wire nx_dpd   = next_state == lp_pkg::ST_DEEP_PD;
    wire nx_low   = nx_deep || nx_pd;
    wire wdosc_on = !pd_cfg[`LP_PD_WDOSC] || keep_wdosc;

    always_comb begin
        next_clk                 = '0;
        next_clk.cpu_clk_en      = next_state == lp_pkg::ST_ACTIVE;
        next_clk.main_clk_en     = nx_run;
        next_clk.periph_clk_en   = nx_run ? {gate1, gate0} : 64'h0000_0000_0000_0000;
        next_clk.wdt_clk_en      = nx_run
                                 || (nx_low && clk_src == lp_pkg::SRC_WDOSC && wdosc_on);
        next_clk.irc_en          = !nx_low && !nx_dpd && !pd_cfg[`LP_PD_IRC];
        next_clk.flash_standby   = nx_deep;
        next_clk.flash_powerdown = nx_pd || nx_dpd;
        // analog blocks drop in deep-sleep and power-down unless held as wake sources, all drop in deep power-down
        next_clk.analog_en       = nx_dpd ? 8'h00
                                 : nx_low ? (~pd_cfg & keep_on)
                                 : ~pd_cfg;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= lp_pkg::ST_ACTIVE;
            clk_ctrl  <= '{cpu_clk_en: 1'b1, main_clk_en: 1'b1,
                           periph_clk_en: {`LP_RST_GATE1, `LP_RST_GATE0},
                           wdt_clk_en: 1'b1, irc_en: !pd_cfg_rst[`LP_PD_IRC],
                           flash_standby: 1'b0, flash_powerdown: 1'b0,
                           analog_en: ~pd_cfg_rst};
            debug_en  <= 1'b1;
            pin_hold  <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            state     <= next_state;
            clk_ctrl  <= next_clk;
            debug_en  <= next_state == lp_pkg::ST_ACTIVE;
            pin_hold  <= next_state == lp_pkg::ST_SLEEP || nx_low;
            reset_req <= next_reset_req;
        end
    end

    assign clk_sel = clk_src;

    // bus clock and one peripheral clock, both stoppable by divide value zero
    lp_clk_div u_bus_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (clk_ctrl.main_clk_en),
        .div     (bus_div),
        .tick    (bus_tick)
    );

    lp_clk_div u_periph_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (clk_ctrl.main_clk_en),
        .div     (periph_div),
        .tick    (periph_tick)
    );

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_sleep_request;
        state == lp_pkg::ST_ACTIVE && wait_for_interrupt_instruction && sel_mode == lp_pkg::MODE_SLEEP;
    endsequence

    sequence seq_deep_wake;
        state == lp_pkg::ST_DEEP_SLEEP && deep_wake;
    endsequence

    chk_reset_active: assert property ($fell(rst) |-> state == lp_pkg::ST_ACTIVE
        && clk_ctrl.cpu_clk_en && clk_ctrl.analog_en == ~`LP_RST_PD_CFG)
        else $error("not active with default power after reset");

    chk_debug_blocked: assert property (state != lp_pkg::ST_ACTIVE |-> !debug_en)
        else $error("debug allowed in a reduced mode");

    chk_sleep_entry: assert property (seq_sleep_request ##0 !irq_pending |=>
        state == lp_pkg::ST_SLEEP && !clk_ctrl.cpu_clk_en && clk_ctrl.main_clk_en)
        else $error("sleep entry did not stop only the cpu clock");

    chk_sleep_periph: assert property (state == lp_pkg::ST_SLEEP |->
        clk_ctrl.periph_clk_en == {gate1, gate0})
        else $error("peripheral gating changed in sleep");

    chk_sleep_wake: assert property (state == lp_pkg::ST_SLEEP && irq_pending |=>
        state == lp_pkg::ST_ACTIVE && $stable(pd_cfg) && $stable(gate0))
        else $error("sleep wake lost configuration");

    chk_deep_gating: assert property (state == lp_pkg::ST_DEEP_SLEEP |->
        !clk_ctrl.main_clk_en && clk_ctrl.periph_clk_en == '0
        && !clk_ctrl.irc_en && clk_ctrl.flash_standby)
        else $error("deep-sleep clocks not gated");

    chk_pin_wake: assert property (state == lp_pkg::ST_DEEP_SLEEP && pin_wake |=>
        state == lp_pkg::ST_SETTLE)
        else $error("enabled pin interrupt did not wake");

    chk_ds_latency: assert property (seq_deep_wake |-> ##201 state == lp_pkg::ST_ACTIVE)
        else $error("deep-sleep wake latency wrong");

    chk_pd_latency: assert property (state == lp_pkg::ST_POWER_DOWN && deep_wake |=>
        (state == lp_pkg::ST_SETTLE && !clk_ctrl.cpu_clk_en)[*8])
        else $error("power-down wake too fast");

    chk_pending_skip: assert property (seq_sleep_request ##0 irq_pending |=>
        state == lp_pkg::ST_ACTIVE)
        else $error("mode entered with wake pending");

    chk_pin_hold: assert property (low_state |-> pin_hold)
        else $error("pins not held in reduced mode");

    chk_reset_gate: assert property (state == lp_pkg::ST_POWER_DOWN && bod_reset_in
        && !keep_bod && !wdt_reset_in |=> !reset_req)
        else $error("brownout reset passed while not kept on");

    chk_flash_pd: assert property (state == lp_pkg::ST_POWER_DOWN |->
        clk_ctrl.flash_powerdown && !clk_ctrl.main_clk_en)
        else $error("power-down flash or clock wrong");

endmodule : lp_power_ctrl

//--- lp_power_ctrl_tb.sv
// self-checking bench of the low power mode controller
// assumes the core model as register master; 20 MHz clock
`timescale 1ns/100ps
`include "lp_consts.svh"
`define CHK(g, e) chk_val(64'(g), 64'(e))
module lp_power_ctrl_tb;
    logic              clk_sys, rst, wait_for_interrupt_instruction, irq_pending, bod_reset_in, wdt_reset_in;
    logic              reset_req, bus_tick, periph_tick, debug_en, pin_hold, rd_seen;
    logic [31:0]       reg_rdata, wake_src0, wake_src1, nested_interrupt_controller_en0, nested_interrupt_controller_en1, g, exp_v;
    logic [1:0]        clk_sel;
    lp_pkg::reg_req_t  reg_req;
    lp_pkg::clk_ctrl_t clk_ctrl;
    logic [31:0]       exp_q[$];
    logic [7:0]        rst_a[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                                     8'h1C, 8'h20, 8'h24};
    logic [31:0]       rst_v[10] = '{32'h0000_0096, 32'h0000_00FF, 32'h0000_0000,
                                     32'h0000_0000, 32'h0000_0000, 32'h0000_0001,
                                     32'h0000_0000, 32'h0000_0000, 32'h0000_0020,
                                     32'h0000_0001};
    int                fails, checked, n_ds, n_pd, bt, pt, d;
    lp_power_ctrl u_lp_power_ctrl (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .wait_for_interrupt_instruction(wait_for_interrupt_instruction), .irq_pending(irq_pending), .wake_src0(wake_src0),
        .wake_src1(wake_src1), .nested_interrupt_controller_en0(nested_interrupt_controller_en0), .nested_interrupt_controller_en1(nested_interrupt_controller_en1),
        .bod_reset_in(bod_reset_in), .wdt_reset_in(wdt_reset_in), .reset_req(reset_req),
        .clk_ctrl(clk_ctrl), .clk_sel(clk_sel), .bus_tick(bus_tick),
        .periph_tick(periph_tick), .debug_en(debug_en), .pin_hold(pin_hold));
    lp_core_model u_lp_core_model (.clk_sys(clk_sys), .reg_req(reg_req), .wait_for_interrupt_instruction(wait_for_interrupt_instruction),
        .irq_pending(irq_pending));
    task automatic chk_val(input logic [63:0] got, input logic [63:0] e);
        checked++;
        if (got !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk_val
    task automatic test_done;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_lp_core_model.reg_rd(a);
    endtask : rd_exp
    // bounded: a core that never wakes must not hang the run
    task automatic wait_cpu(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (clk_ctrl.cpu_clk_en !== 1'b1 && n < 2000);
    endtask : wait_cpu
    task automatic pulse_rst;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        bod_reset_in <= 1'b0;
    endtask : pulse_rst
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // read data stand from the cycle after the strobe until the next read
    always @(posedge clk_sys) begin
        if (rd_seen === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v);
        end
        rd_seen <= reg_req.rd;
    end
    initial begin
        #(50 * 40000);
        fails++;
        test_done();
    end
    initial begin
        {rst, bod_reset_in, wdt_reset_in, rd_seen} = 4'b1000;
        {wake_src0, wake_src1, nested_interrupt_controller_en0, nested_interrupt_controller_en1} = '0;
        g = $urandom(32'h0266_eb6e);
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rst_a[i]) rd_exp(rst_a[i], rst_v[i]);
        rd_exp(8'h28, 32'h0000_0000);
        `CHK(clk_ctrl.periph_clk_en, 64'h0000_0000_0000_00FF);
        `CHK({clk_ctrl.analog_en, debug_en, pin_hold}, 10'h1A6);
        `CHK({clk_ctrl.wdt_clk_en, clk_ctrl.irc_en, clk_sel}, 4'b1100);
        $display("test reset values done");
        g = $urandom;
        u_lp_core_model.reg_wr(`LP_ADDR_GATE1, g);
        u_lp_core_model.reg_wr(`LP_ADDR_STATUS, 32'hFFFF_FFFF);
        rd_exp(`LP_ADDR_GATE1, g);
        rd_exp(`LP_ADDR_STATUS, 32'h0000_0020);
        `CHK(clk_ctrl.periph_clk_en[63:32], g);
        u_lp_core_model.reg_wr(`LP_ADDR_CLK_SEL, g);
        rd_exp(`LP_ADDR_CLK_SEL, {30'h0000_0000, g[1:0]});
        `CHK(clk_sel, g[1:0]);
        u_lp_core_model.reg_wr(`LP_ADDR_CLK_SEL, 32'h0000_0000);
        $display("test register access done");
        u_lp_core_model.set_irq(1'b1);
        u_lp_core_model.enter_mode(2'd0, 8'h00);
        @(posedge clk_sys);
        `CHK(clk_ctrl.cpu_clk_en, 1'b1);
        u_lp_core_model.set_irq(1'b0);
        u_lp_core_model.enter_mode(2'd0, 8'h00);
        @(posedge clk_sys);
        `CHK({clk_ctrl.cpu_clk_en, clk_ctrl.main_clk_en}, 2'b01);
        `CHK(clk_ctrl.periph_clk_en, {g, 32'h0000_00FF});
        `CHK({debug_en, pin_hold}, 2'b01);
        rd_exp(`LP_ADDR_STATUS, 32'h0000_0011);
        u_lp_core_model.set_irq(1'b1);
        wait_cpu(d);
        `CHK(d <= 2, 1'b1);
        u_lp_core_model.set_irq(1'b0);
        rd_exp(`LP_ADDR_GATE1, g);
        $display("test sleep done");
        u_lp_core_model.reg_wr(`LP_ADDR_WAKE_EN0, 32'h0000_0001);
        nested_interrupt_controller_en0 <= 32'h0000_0003;
        u_lp_core_model.enter_mode(2'd1, 8'h00);
        @(posedge clk_sys);
        `CHK({clk_ctrl.main_clk_en, clk_ctrl.irc_en, clk_ctrl.flash_standby}, 3'b001);
        `CHK(clk_ctrl.periph_clk_en, 64'h0000_0000_0000_0000);
        wake_src0 <= 32'h0000_0002;
        repeat (5) @(posedge clk_sys);
        `CHK(clk_ctrl.cpu_clk_en, 1'b0);
        wake_src0 <= 32'h0000_0001;
        wait_cpu(n_ds);
        wake_src0 <= 32'h0000_0000;
        `CHK(n_ds >= 200 && n_ds < 2000, 1'b1);
        $display("test deep-sleep done");
        u_lp_core_model.reg_wr(`LP_ADDR_WAKE_EN1, 32'h0000_0001);
        nested_interrupt_controller_en1 <= 32'h0000_0001;
        u_lp_core_model.enter_mode(2'd2, 8'h00);
        @(posedge clk_sys);
        `CHK({clk_ctrl.main_clk_en, clk_ctrl.wdt_clk_en, clk_ctrl.flash_powerdown}, 3'b001);
        rd_exp(`LP_ADDR_STATUS, 32'h0000_0013);
        wake_src1 <= 32'h0000_0001;
        wait_cpu(n_pd);
        wake_src1 <= 32'h0000_0000;
        `CHK(n_pd > n_ds && n_pd < 2000, 1'b1);
        $display("test power-down done");
        u_lp_core_model.enter_mode(2'd1, 8'h20);
        @(posedge clk_sys);
        `CHK(clk_ctrl.analog_en, 8'h20);
        bod_reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(reset_req, 1'b1);
        pulse_rst();
        rd_exp(`LP_ADDR_STATUS, 32'h0000_0020);
        wdt_reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(reset_req, 1'b1);
        wdt_reset_in <= 1'b0;
        u_lp_core_model.enter_mode(2'd2, 8'h00);
        @(posedge clk_sys);
        bod_reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(reset_req, 1'b0);
        pulse_rst();
        u_lp_core_model.enter_mode(2'd3, 8'h00);
        @(posedge clk_sys);
        `CHK(debug_en, 1'b0);
        pulse_rst();
        rd_exp(`LP_ADDR_PD_CFG, 32'h0000_0096);
        $display("test reset wake done");
        d = $urandom_range(4, 2);
        u_lp_core_model.reg_wr(`LP_ADDR_PERIPH_DIV, 32'h0000_0000);
        u_lp_core_model.reg_wr(`LP_ADDR_BUS_DIV, d);
        repeat (3) @(posedge clk_sys);
        {bt, pt} = '0;
        repeat (24) begin
            @(posedge clk_sys);
            bt += int'(bus_tick === 1'b1);
            pt += int'(periph_tick === 1'b1);
        end
        `CHK(pt, 0);
        `CHK(bt, 24 / d);
        $display("test dividers done");
        repeat (3) @(posedge clk_sys);
        test_done();
    end
endmodule : lp_power_ctrl_tb

//--- lp_settle_timer.sv
// down counter that holds a wake sequence while analog blocks settle
// assumes load is a single-cycle pulse with a nonzero count
`timescale 1ns/100ps
module lp_settle_timer (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [10:0] count,
    output logic             done
);
    logic [10:0] cnt;

    assign done = (cnt == 11'h001);

    always_ff @(posedge clk_sys) begin
        if (rst)
            cnt <= 11'h000;
        else if (load)
            cnt <= count;
        else if (cnt != 11'h000)
            cnt <= cnt - 11'h001;
    end
endmodule : lp_settle_timer
